// *** core/usp_params.svh ***
// constants for the upconverter sync and profile register bank
// assumes a byte-serial host port with 5-bit register addresses
`ifndef USP_PARAMS_SVH
`define USP_PARAMS_SVH

`define USP_ADDR_MSYNC    5'h0A
`define USP_ADDR_PROF0    5'h0E
`define USP_ADDR_PROF7    5'h15
`define USP_ADDR_RAM      5'h16
`define USP_ADDR_GPCFG    5'h18
`define USP_ADDR_GPDAT    5'h19

// index of the last byte of each register (byte count minus one)
`define USP_LAST_MSYNC    3'h3
`define USP_LAST_PROF     3'h7
`define USP_LAST_RAM      3'h3
`define USP_LAST_GPIO     3'h1
`define USP_LAST_NONE     3'h0

`define USP_RD_BIT        7
`define USP_MSYNC_RST     32'h0000_0000
`define USP_MSYNC_WMASK   32'hFEFC_F8F8
`define USP_PROF_RST      64'h0000_0000_0000_0000
`define USP_TONE_RMASK    64'h3FFF_FFFF_FFFF_FFFF
`define USP_GPIO_RST      16'h0000
`define USP_SYNC_STEP_PS  75

`define USP_MODE_UPC      2'h0
`define USP_MODE_TONE     2'h1
`define USP_MODE_DAC      2'h2
`define USP_MODE_RSVD     2'h3

`define USP_RAM_AW        10
`define USP_RAM_WORDS     1024

`endif

// *** core/usp_pkg.sv ***
// types shared by the serial port and the register bank
// assumes usp_params.svh is on the include path
package usp_pkg;
`include "usp_params.svh"

  typedef enum logic [1:0] {
    USP_UPC  = `USP_MODE_UPC,
    USP_TONE = `USP_MODE_TONE,
    USP_DAC  = `USP_MODE_DAC,
    USP_RSVD = `USP_MODE_RSVD
  } usp_mode_t;

  typedef struct packed {
    logic [3:0] valid_dly;
    logic       rx_en;
    logic       gen_en;
    logic       gen_pol;
    logic       open_24;
    logic [5:0] preset;
    logic [1:0] open_17;
    logic [4:0] gen_dly;
    logic [2:0] open_10;
    logic [4:0] rx_dly;
    logic [2:0] open_2;
  } usp_msync_t;

  typedef struct packed {
    logic [13:0] asf;
    logic [15:0] pow;
    logic [31:0] ftw;
  } usp_tone_t;

  typedef struct packed {
    logic [5:0]  comb_rate;
    logic        spec_inv;
    logic        inv_comb_byp;
    logic [7:0]  osf;
    logic [15:0] pow;
    logic [31:0] ftw;
  } usp_upc_t;

  typedef struct packed {
    logic        start;
    logic        rd;
    logic        wr;
    logic        rd_adv;
    logic [4:0]  addr;
    logic [63:0] wdata;
  } usp_ser_req_t;

  function automatic logic [2:0] usp_last_byte(input logic [4:0] a);
    if (a == `USP_ADDR_MSYNC || a == `USP_ADDR_RAM)
      return `USP_LAST_MSYNC;
    else if (a >= `USP_ADDR_PROF0 && a <= `USP_ADDR_PROF7)
      return `USP_LAST_PROF;
    else if (a == `USP_ADDR_GPCFG || a == `USP_ADDR_GPDAT)
      return `USP_LAST_GPIO;
    else
      return `USP_LAST_NONE;
  endfunction
endpackage

// *** core/usp_regs_top.sv ***
// sync, profile, waveform port and gpio registers of the upconverter
// assumes the mode field and selected memory segment come from outside
`timescale 1ns/1ps
`include "usp_params.svh"
module usp_regs_top
  import usp_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // serial host port
  input  wire logic                io_sclk,
  input  wire logic                io_cs_n,
  input  wire logic                io_sdi,
  output      logic                io_sdo,
  output      logic                io_sdo_oe,
  // profile selection
  input  wire logic                profile_select_pin_0,
  input  wire logic                profile_select_pin_1,
  input  wire logic                profile_select_pin_2,
  input  wire logic [1:0]          control_function_reg_one_mode,
  output      usp_pkg::usp_tone_t  active_tone,
  output      usp_pkg::usp_upc_t   active_upc,
  // selected waveform memory segment
  input  wire logic [9:0]          ram_seg_start,
  input  wire logic [9:0]          ram_seg_end,
  // multichip sync
  input  wire logic                sync_pulse_in,
  output      usp_pkg::usp_msync_t sync_cfg,
  output      logic [5:0]          clk_state,
  output      logic                sync_gen_out,
  output      logic                sync_gen_falling,
  // gpio pins
  input  wire logic [15:0]         gpio_in,
  output      logic [15:0]         gpio_out,
  output      logic [15:0]         gpio_oe
);
  import usp_pkg::*;

  usp_ser_req_t req;
  logic [63:0]  rd_word;
  logic [63:0]  rd_raw;
  logic [31:0]  msync_reg;
  logic [63:0]  prof_reg [8];
  logic [31:0]  ram_mem [`USP_RAM_WORDS];
  logic [`USP_RAM_AW-1:0] ram_ptr;
  logic [10:0]  ram_cnt;
  logic [10:0]  ram_span;
  logic [15:0]  gpio_cfg_reg;
  logic [15:0]  gpio_dat_reg;
  logic [4:0]   prof_off;
  logic [2:0]   prof_idx;
  logic         is_prof;
  logic [2:0]   sel;
  logic [63:0]  sel_word;
  usp_mode_t    mode;
  logic         ram_go;

  usp_serial_port u_port (
    .clk       (clk),
    .rst       (rst),
    .io_sclk   (io_sclk),
    .io_cs_n   (io_cs_n),
    .io_sdi    (io_sdi),
    .io_sdo    (io_sdo),
    .io_sdo_oe (io_sdo_oe),
    .req       (req),
    .rd_word   (rd_word)
  );

  assign prof_off = req.addr - `USP_ADDR_PROF0;
  assign prof_idx = prof_off[2:0];
  assign is_prof  = req.addr >= `USP_ADDR_PROF0 &&
                    req.addr <= `USP_ADDR_PROF7;
  assign mode     = usp_mode_t'(control_function_reg_one_mode);
  assign sel      = {profile_select_pin_2, profile_select_pin_1,
                     profile_select_pin_0};
  assign sel_word = prof_reg[sel];
  assign ram_go   = req.addr == `USP_ADDR_RAM && ram_cnt != 11'h000;
  assign ram_span = (ram_seg_end >= ram_seg_start) ?
                    11'({1'h0, ram_seg_end} - {1'h0, ram_seg_start}) + 11'h001
                    : 11'h000;

  // multichip sync register; open bits never stored
  always_ff @(posedge clk or posedge rst)
    if (rst)
      msync_reg <= `USP_MSYNC_RST;
    else if (req.wr && req.addr == `USP_ADDR_MSYNC)
      msync_reg <= req.wdata[31:0] & `USP_MSYNC_WMASK;

  // delay codes feed the analog delay lines in 75 ps steps
  assign sync_cfg = usp_msync_t'(msync_reg);

  always_ff @(posedge clk or posedge rst)
    if (rst)
      clk_state <= 6'h00;
    else if (sync_pulse_in && sync_cfg.rx_en)
      clk_state <= sync_cfg.preset;
    else
      clk_state <= clk_state + 6'h01;

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      sync_gen_out     <= 1'h0;
      sync_gen_falling <= 1'h0;
    end
    else
    begin
      sync_gen_out     <= sync_cfg.gen_en && clk_state == 6'h00;
      // the edge choice is applied by the output retiming cell
      sync_gen_falling <= sync_cfg.gen_pol;
    end

  // one generated block per profile slot
  for (genvar g = 0; g < 8; g++)
  begin : g_prof
    always_ff @(posedge clk or posedge rst)
      if (rst)
        prof_reg[g] <= `USP_PROF_RST;
      else if (req.wr && is_prof && prof_idx == 3'(g))
        prof_reg[g] <= req.wdata;
  end

  // active profile, decoded by mode
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      active_tone <= '0;
      active_upc  <= '0;
    end
    else
      case (mode)
        USP_UPC:
        begin
          active_tone <= '0;
          active_upc  <= usp_upc_t'(sel_word);
        end
        USP_DAC:
        begin
          active_tone <= '0;
          // frequency, phase and spectral sign are meaningless here
          active_upc  <= '{comb_rate: sel_word[63:58], spec_inv: 1'h0,
                           inv_comb_byp: sel_word[56],
                           osf: sel_word[55:48], pow: 16'h0000,
                           ftw: 32'h0000_0000};
        end
        default:
        begin
          active_tone <= usp_tone_t'(sel_word[61:0]);
          active_upc  <= '0;
        end
      endcase

  // waveform port: words beyond the segment span are dropped
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      ram_ptr <= '0;
      ram_cnt <= 11'h000;
    end
    else if (req.start && req.addr == `USP_ADDR_RAM)
    begin
      ram_ptr <= ram_seg_start;
      ram_cnt <= ram_span;
    end
    else if ((req.wr || req.rd_adv) && ram_go)
    begin
      ram_ptr <= ram_ptr + 10'h001;
      ram_cnt <= ram_cnt - 11'h001;
    end

  always_ff @(posedge clk)
    if (req.wr && ram_go)
      ram_mem[ram_ptr] <= req.wdata[31:0];

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      gpio_cfg_reg <= `USP_GPIO_RST;
      gpio_dat_reg <= `USP_GPIO_RST;
    end
    else if (req.wr && req.addr == `USP_ADDR_GPCFG)
      gpio_cfg_reg <= req.wdata[15:0];
    else if (req.wr && req.addr == `USP_ADDR_GPDAT)
      gpio_dat_reg <= (gpio_dat_reg & ~gpio_cfg_reg) |
                      (req.wdata[15:0] & gpio_cfg_reg);

  assign gpio_out = gpio_dat_reg;
  assign gpio_oe  = gpio_cfg_reg;

  // read data, left aligned so the port shifts out from bit 63
  always_comb
  begin
    rd_raw = 64'h0;
    if (req.addr == `USP_ADDR_MSYNC)
      rd_raw = {32'h0, msync_reg};
    else if (is_prof)
      rd_raw = (mode == USP_UPC || mode == USP_DAC) ? prof_reg[prof_idx]
               : prof_reg[prof_idx] & `USP_TONE_RMASK;
    // the pointer loads on this same strobe, so read the segment start
    else if (req.start && req.addr == `USP_ADDR_RAM)
      rd_raw = (ram_span != 11'h000) ? {32'h0, ram_mem[ram_seg_start]}
               : 64'h0;
    else if (ram_go)
      rd_raw = {32'h0, ram_mem[ram_ptr]};
    else if (req.addr == `USP_ADDR_GPCFG)
      rd_raw = {48'h0, gpio_cfg_reg};
    else if (req.addr == `USP_ADDR_GPDAT)
      rd_raw = {48'h0, (gpio_dat_reg & gpio_cfg_reg) |
                       (gpio_in & ~gpio_cfg_reg)};
  end

  assign rd_word = rd_raw <<
                   {(3'h7 - usp_last_byte(req.addr)), 3'h0};

  property p_open_zero;
    @(posedge clk) disable iff (rst)
      (msync_reg & ~`USP_MSYNC_WMASK) == 32'h0;
  endproperty
  a_open_zero: assert property (p_open_zero)
    else $error("open sync bits stored");

  property p_preset;
    @(posedge clk) disable iff (rst)
      sync_pulse_in && sync_cfg.rx_en |=> clk_state == $past(sync_cfg.preset);
  endproperty
  a_preset: assert property (p_preset)
    else $error("preset not loaded on sync pulse");

  property p_rx_off;
    @(posedge clk) disable iff (rst)
      // the counter is still held on the edge that releases reset
      !sync_cfg.rx_en ##1 !$past(rst)
      |-> clk_state == 6'($past(clk_state) + 6'h01);
  endproperty
  a_rx_off: assert property (p_rx_off)
    else $error("sync pulse taken while receiver off");

  property p_gen_off;
    @(posedge clk) disable iff (rst)
      !sync_cfg.gen_en [*2] |-> !sync_gen_out;
  endproperty
  a_gen_off: assert property (p_gen_off)
    else $error("generator output while disabled");

  property p_pol;
    @(posedge clk) disable iff (rst)
      req.wr && req.addr == `USP_ADDR_MSYNC
      |-> ##2 sync_gen_falling == $past(req.wdata[25], 2);
  endproperty
  a_pol: assert property (p_pol)
    else $error("polarity not applied");

  property p_select;
    @(posedge clk) disable iff (rst)
      mode == USP_TONE |=> active_tone.ftw == $past(sel_word[31:0]);
  endproperty
  a_select: assert property (p_select)
    else $error("active profile does not follow pins");

  property p_dac;
    @(posedge clk) disable iff (rst)
      mode == USP_DAC |=> active_upc.ftw == 32'h0 && !active_upc.spec_inv
                          && active_upc.osf == $past(sel_word[55:48]);
  endproperty
  a_dac: assert property (p_dac)
    else $error("dac mode leaks frequency or sign");

  property p_mode;
    @(posedge clk) disable iff (rst)
      mode == USP_UPC |=> active_tone == '0 &&
                          active_upc.comb_rate == $past(sel_word[63:58]);
  endproperty
  a_mode: assert property (p_mode)
    else $error("profile decode ignores mode");

  property p_ram_span;
    @(posedge clk) disable iff (rst)
      req.start && req.addr == `USP_ADDR_RAM |=> ram_cnt == $past(ram_span);
  endproperty
  a_ram_span: assert property (p_ram_span)
    else $error("word count differs from segment span");

  property p_gpio;
    @(posedge clk) disable iff (rst)
      req.wr && req.addr == `USP_ADDR_GPDAT
      |=> ((gpio_dat_reg ^ $past(gpio_dat_reg)) & ~gpio_cfg_reg) == 16'h0;
  endproperty
  a_gpio: assert property (p_gpio)
    else $error("input gpio bit written");

  c_ram_word: cover property (@(posedge clk) disable iff (rst)
    req.wr && ram_go);
  c_sync: cover property (@(posedge clk) disable iff (rst)
    sync_pulse_in && sync_cfg.rx_en);
  c_read: cover property (@(posedge clk) disable iff (rst)
    req.start && req.rd && is_prof);
endmodule

// *** core/usp_serial_port.sv ***
// byte-serial host port: instruction byte then register bytes, msb first
// assumes sclk, cs_n and sdi are synchronous to clk and much slower
`timescale 1ns/1ps
module usp_serial_port
  import usp_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // serial pins
  input  wire logic                  io_sclk,
  input  wire logic                  io_cs_n,
  input  wire logic                  io_sdi,
  output      logic                  io_sdo,
  output      logic                  io_sdo_oe,
  // register side
  output      usp_pkg::usp_ser_req_t req,
  input  wire logic [63:0]           rd_word
);
  import usp_pkg::*;

  typedef enum logic [2:0] {
    SP_INSTR = 3'b001,
    SP_DATA  = 3'b010,
    SP_HOLD  = 3'b100
  } usp_sp_state_t;

  usp_sp_state_t state_reg;
  logic          sclk_q;
  logic [2:0]    bit_cnt;
  logic [2:0]    byte_cnt;
  logic [7:0]    ins_reg;
  logic [63:0]   shift_reg;
  logic [63:0]   out_sh;
  logic [63:0]   wdata_q;
  logic          start_q;
  logic          wr_q;
  logic          adv_q;
  logic          load_q;
  logic          rise;
  logic          word_end;
  logic          is_rd;

  assign rise     = io_sclk & ~sclk_q & ~io_cs_n;
  assign is_rd    = ins_reg[`USP_RD_BIT];
  assign word_end = rise && state_reg == SP_DATA && bit_cnt == 3'h7 &&
                    byte_cnt == usp_last_byte(ins_reg[4:0]);

  always_ff @(posedge clk or posedge rst)
    if (rst)
      sclk_q <= 1'h0;
    else
      sclk_q <= io_sclk;

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      state_reg <= SP_INSTR;
      bit_cnt   <= 3'h0;
      byte_cnt  <= 3'h0;
      ins_reg   <= 8'h00;
      shift_reg <= 64'h0;
    end
    else if (io_cs_n)
    begin
      state_reg <= SP_INSTR;
      bit_cnt   <= 3'h0;
      byte_cnt  <= 3'h0;
    end
    else if (rise)
    begin
      bit_cnt <= bit_cnt + 3'h1;
      case (state_reg)
        SP_INSTR:
        begin
          ins_reg <= {ins_reg[6:0], io_sdi};
          if (bit_cnt == 3'h7)
            state_reg <= SP_DATA;
        end
        SP_DATA:
        begin
          shift_reg <= {shift_reg[62:0], io_sdi};
          if (word_end)
          begin
            byte_cnt <= 3'h0;
            // the waveform port streams words until the frame ends
            if (ins_reg[4:0] != `USP_ADDR_RAM)
              state_reg <= SP_HOLD;
          end
          else if (bit_cnt == 3'h7)
            byte_cnt <= byte_cnt + 3'h1;
        end
        SP_HOLD: ;
        default: state_reg <= SP_INSTR;
      endcase
    end

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      start_q <= 1'h0;
      wr_q    <= 1'h0;
      adv_q   <= 1'h0;
      load_q  <= 1'h0;
      wdata_q <= 64'h0;
    end
    else
    begin
      start_q <= rise && state_reg == SP_INSTR && bit_cnt == 3'h7;
      wr_q    <= word_end && !is_rd;
      adv_q   <= word_end && is_rd;
      load_q  <= adv_q;
      if (word_end)
        wdata_q <= {shift_reg[62:0], io_sdi};
    end

  // next output bit is presented after the rising edge the host samples on
  always_ff @(posedge clk or posedge rst)
    if (rst)
      out_sh <= 64'h0;
    else if ((start_q || load_q) && is_rd)
      out_sh <= rd_word;
    else if (rise && state_reg == SP_DATA && is_rd)
      out_sh <= {out_sh[62:0], 1'h0};

  assign io_sdo    = out_sh[63];
  assign io_sdo_oe = ~io_cs_n & is_rd & (state_reg == SP_DATA);
  assign req = '{start: start_q, rd: is_rd, wr: wr_q, rd_adv: adv_q,
                 addr: ins_reg[4:0], wdata: wdata_q};
endmodule

// *** dv/tb_top.sv ***
// testbench for the sync, profile, waveform and gpio register bank
// assumes the host model drives the serial pins for every access
`timescale 1ns/1ps
`include "usp_params.svh"
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); \
    end \
  end
module tb_top;
  import usp_pkg::*;
  logic               clk;
  logic               rst;
  logic               io_sclk;
  logic               io_cs_n;
  logic               io_sdi;
  logic               io_sdo;
  logic               io_sdo_oe;
  logic               psel0;
  logic               psel1;
  logic               psel2;
  logic [1:0]         cfr_mode;
  usp_tone_t          active_tone;
  usp_upc_t           active_upc;
  logic [9:0]         seg_start;
  logic [9:0]         seg_end;
  logic               sync_pulse_in;
  usp_msync_t         sync_cfg;
  logic [5:0]         clk_state;
  logic               sync_gen_out;
  logic               sync_gen_falling;
  logic [15:0]        gpio_in;
  logic [15:0]        gpio_out;
  logic [15:0]        gpio_oe;
  int                 n_errors = 0;
  int                 total_checks = 0;

  usp_regs_top i_dut (
    .clk(clk), .rst(rst), .io_sclk(io_sclk), .io_cs_n(io_cs_n),
    .io_sdi(io_sdi), .io_sdo(io_sdo), .io_sdo_oe(io_sdo_oe),
    .profile_select_pin_0(psel0), .profile_select_pin_1(psel1),
    .profile_select_pin_2(psel2), .control_function_reg_one_mode(cfr_mode),
    .active_tone(active_tone), .active_upc(active_upc),
    .ram_seg_start(seg_start), .ram_seg_end(seg_end),
    .sync_pulse_in(sync_pulse_in), .sync_cfg(sync_cfg),
    .clk_state(clk_state), .sync_gen_out(sync_gen_out),
    .sync_gen_falling(sync_gen_falling), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe)
  );

  usp_host_model i_host (
    .clk(clk), .io_sclk(io_sclk), .io_cs_n(io_cs_n), .io_sdi(io_sdi),
    .io_sdo(io_sdo), .io_sdo_oe(io_sdo_oe)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input int n, input logic [63:0] v);
    logic [63:0] r;
    i_host.reg_access(1'b0, a, n, v, r);
  endtask

  task automatic rd_chk(input logic [4:0] a, input int n,
                        input logic [63:0] e);
    logic [63:0] r;
    i_host.reg_access(1'b1, a, n, 64'h0, r);
    `CHK(r, e)
  endtask

  function automatic logic [63:0] pv(input int i);
    return 64'hE3A5_5A3C_0F1E_2D4B ^ {8{5'h00, 3'(i)}};
  endfunction

  // pulse lands far from the preset so a natural count cannot fake a load
  task automatic sync_probe(input logic rx_on, input logic gen_on,
                            input logic [5:0] pre);
    int n;
    logic hit;
    logic [5:0] s0;
    n = 0;
    hit = 1'b0;
    repeat (64)
    begin
      @(posedge clk);
      if (sync_gen_out === 1'b1)
        n++;
    end
    `CHK(n, gen_on ? 1 : 0)
    for (int k = 0; k < 70 && clk_state !== 6'h35; k++)
      @(posedge clk);
    s0 = clk_state;
    sync_pulse_in <= 1'b1;
    @(posedge clk);
    sync_pulse_in <= 1'b0;
    repeat (4)
    begin
      @(posedge clk);
      if (clk_state === pre)
        hit = 1'b1;
    end
    if (rx_on)
      `CHK(hit, 1'b1)
    else
      `CHK(clk_state, s0 + 6'd5)
  endtask

  task automatic t_reset();
    `CHK(sync_cfg, `USP_MSYNC_RST)
    `CHK(gpio_oe, `USP_GPIO_RST)
    `CHK(gpio_out, `USP_GPIO_RST)
    rd_chk(`USP_ADDR_MSYNC, 32, 64'h0);
    sync_probe(1'b0, 1'b0, 6'h00);
  endtask

  task automatic t_msync();
    wr(`USP_ADDR_MSYNC, 32, 64'h5D57_9F5F);
    `CHK(sync_cfg, 32'h5C54_9858)
    `CHK(sync_gen_falling, 1'b0)
    rd_chk(`USP_ADDR_MSYNC, 32, 64'h5C54_9858);
    sync_probe(1'b1, 1'b1, 6'h15);
    wr(`USP_ADDR_MSYNC, 32, 64'h0200_0000);
    `CHK(sync_gen_falling, 1'b1)
    sync_probe(1'b0, 1'b0, 6'h00);
  endtask

  task automatic t_profiles();
    logic [63:0] v;
    logic [63:0] eq;
    logic [61:0] et;
    for (int i = 0; i < 8; i++)
      wr(`USP_ADDR_PROF0 + 5'(i), 64, pv(i));
    for (int m = 0; m < 4; m++)
    begin
      cfr_mode <= 2'(m);
      for (int i = 0; i < 8; i++)
      begin
        {psel2, psel1, psel0} <= 3'(i);
        repeat (3) @(posedge clk);
        v = pv(i);
        eq = (m == 0) ? v : (m == 2) ? v & 64'hFDFF_0000_0000_0000 : 64'h0;
        et = (m == 1 || m == 3) ? v[61:0] : 62'h0;
        `CHK(active_upc, eq)
        `CHK(active_tone, et)
      end
    end
    cfr_mode <= USP_TONE;
    repeat (2) @(posedge clk);
    rd_chk(`USP_ADDR_PROF0 + 5'h3, 64, pv(3) & `USP_TONE_RMASK);
    cfr_mode <= USP_UPC;
    repeat (2) @(posedge clk);
    rd_chk(`USP_ADDR_PROF7, 64, pv(7));
  endtask

  task automatic t_gpio();
    wr(`USP_ADDR_GPCFG, 16, 64'h00FF);
    `CHK(gpio_oe, 16'h00FF)
    wr(`USP_ADDR_GPDAT, 16, 64'hA5A5);
    `CHK(gpio_out, 16'h00A5)
    wr(`USP_ADDR_GPCFG, 16, 64'hFF00);
    wr(`USP_ADDR_GPDAT, 16, 64'h5A5A);
    `CHK(gpio_out, 16'h5AA5)
    rd_chk(`USP_ADDR_GPCFG, 16, 64'hFF00);
    rd_chk(`USP_ADDR_GPDAT, 16, 64'h5A3C);
    wr(5'h1F, 8, 64'hFF);
    rd_chk(5'h1F, 8, 64'h0);
  endtask

  // four words against a three-word segment: the last one must drop
  task automatic t_ram();
    logic [63:0] r;
    logic [31:0] w [4];
    w = '{32'hDEAD_0001, 32'h1234_5678, 32'h8000_00FF, 32'hFFFF_FFFF};
    seg_start <= 10'h00A;
    seg_end <= 10'h00C;
    for (int p = 0; p < 2; p++)
    begin
      i_host.begin_frame();
      i_host.shift(8, {56'h0, p[0], 2'b00, `USP_ADDR_RAM}, r);
      for (int k = 0; k < 4; k++)
      begin
        i_host.shift(32, {32'h0, w[k]}, r);
        if (p == 1)
          `CHK(r[31:0], (k < 3) ? w[k] : 32'h0)
      end
      i_host.end_frame();
    end
  endtask

  initial
  begin
    rst = 1'b1;
    {psel2, psel1, psel0} = 3'h0;
    cfr_mode = USP_UPC;
    seg_start = 10'h000;
    seg_end = 10'h000;
    sync_pulse_in = 1'b0;
    gpio_in = 16'h3C3C;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_msync();
    t_profiles();
    t_gpio();
    t_ram();
    final_report();
  end

  // whole sequence needs about 13k clocks
  initial
  begin
    #3_000_000;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
endmodule

// *** dv/usp_host_model.sv ***
// host processor model driving the byte-serial register port
// assumes the device samples sdi on sclk rise and clk is free running
`timescale 1ns/1ps
module usp_host_model (
  // system clock
  input  wire logic clk,
  // serial pins
  output      logic io_sclk,
  output      logic io_cs_n,
  output      logic io_sdi,
  input  wire logic io_sdo,
  input  wire logic io_sdo_oe
);
  logic in_frame;

  initial
  begin
    io_sclk = 1'b0;
    io_cs_n = 1'b1;
    io_sdi = 1'b0;
    in_frame = 1'b0;
  end

  // sdi means nothing between frames, so keep it moving
  always @(posedge clk)
    if (!in_frame)
      io_sdi <= ~io_sdi;

  task automatic begin_frame();
    @(posedge clk);
    in_frame = 1'b1;
    @(posedge clk);
    io_cs_n <= 1'b0;
  endtask

  // msb first; sclk low 5 and high 4 clocks, read bit taken before rise
  task automatic shift(input int nbits, input logic [63:0] wval,
                       output logic [63:0] rval);
    rval = '0;
    for (int i = nbits - 1; i >= 0; i--)
    begin
      @(posedge clk);
      io_sdi <= wval[i];
      repeat (4) @(posedge clk);
      rval[i] = io_sdo_oe ? io_sdo : 1'bx;
      io_sclk <= 1'b1;
      repeat (4) @(posedge clk);
      io_sclk <= 1'b0;
    end
  endtask

  task automatic end_frame();
    repeat (2) @(posedge clk);
    io_cs_n <= 1'b1;
    repeat (4) @(posedge clk);
    in_frame = 1'b0;
  endtask

  // whole register per frame, instruction first
  task automatic reg_access(input logic rd, input logic [4:0] addr,
                            input int nbits, input logic [63:0] wval,
                            output logic [63:0] rval);
    logic [63:0] ign;
    begin_frame();
    shift(8, {56'h0, rd, 2'b00, addr}, ign);
    shift(nbits, wval, rval);
    end_frame();
  endtask
endmodule
